// [src/gmc_defs.svh]
`ifndef GMC_DEFS_SVH
`define GMC_DEFS_SVH
// ****************************************
// Register map
// ****************************************
`define GMC_OFF_CAL 9'h1C8
`define GMC_OFF_SETUP 9'h1C9
`define GMC_OFF_CURVE 9'h1CA
// ****************************************
// Fields and reset values
// ****************************************
`define GMC_GAIN_HI 15
`define GMC_GAIN_LO 6
`define GMC_OFFS_HI 5
`define GMC_PULLUP_BIT 7
`define GMC_TSRC_BIT 4
`define GMC_SENSE_BIT 2
`define GMC_SETUP_MASK 16'hEF97
`define GMC_CAL_RST 16'h4000
`define GMC_SETUP_RST 16'h0010
`define GMC_CURVE_RST 16'h71BE
`define GMC_GAIN_SHIFT 8
`endif

// [src/gmc_pkg.sv]
package gmc_pkg;
  typedef logic [15:0] gmc_word_t;
  typedef logic signed [15:0] gmc_cur_t;
  typedef enum logic {GMC_TSRC_DIE, GMC_TSRC_THERM} gmc_tsrc_e;
endpackage : gmc_pkg

// [src/gmc_config.sv]
`timescale 1ns/1ps
`include "gmc_defs.svh"
module gmc_config (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] reg_addr,
  input wire gmc_pkg::gmc_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output gmc_pkg::gmc_word_t reg_rdata,
  input wire gmc_pkg::gmc_cur_t raw_current,
  input wire logic raw_valid,
  input wire gmc_pkg::gmc_word_t die_temperature,
  input wire gmc_pkg::gmc_word_t thermistor_temp,
  input wire gmc_pkg::gmc_word_t ext_temp_overwrite,
  input wire logic ext_override_en,
  output gmc_pkg::gmc_cur_t reported_current,
  output logic current_valid,
  output gmc_pkg::gmc_word_t temperature,
  output logic pullup_strength_select,
  output logic sense_resistor_select,
  output gmc_pkg::gmc_word_t thermistor_curve_word
);
  import gmc_pkg::*;
  // ****************************************
  // Registers
  // ****************************************
  gmc_word_t cal_r;
  gmc_word_t setup_r;
  gmc_word_t curve_r;
  gmc_word_t rdata_nxt;
  logic [9:0] current_gain_factor;
  logic signed [5:0] current_offset_trim;
  logic signed [27:0] raw_ext;
  logic signed [27:0] gain_ext;
  logic signed [27:0] product;
  logic signed [27:0] scaled;
  gmc_tsrc_e temperature_source_select;

  always_ff @(posedge clk) begin
    if (rst) begin
      cal_r <= `GMC_CAL_RST;
    end else if (reg_wr && reg_addr == `GMC_OFF_CAL) begin
      cal_r <= reg_wdata;
    end
  end

  // Undefined setup bits are masked so they never store
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_r <= `GMC_SETUP_RST;
    end else if (reg_wr && reg_addr == `GMC_OFF_SETUP) begin
      setup_r <= reg_wdata & `GMC_SETUP_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      curve_r <= `GMC_CURVE_RST;
    end else if (reg_wr && reg_addr == `GMC_OFF_CURVE) begin
      curve_r <= reg_wdata;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    case (reg_addr)
      `GMC_OFF_CAL: rdata_nxt = cal_r;
      `GMC_OFF_SETUP: rdata_nxt = setup_r & `GMC_SETUP_MASK;
      `GMC_OFF_CURVE: rdata_nxt = curve_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Unmapped reads and idle cycles return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // Current trim
  // ****************************************
  assign current_gain_factor = cal_r[`GMC_GAIN_HI:`GMC_GAIN_LO];
  assign current_offset_trim = $signed(cal_r[`GMC_OFFS_HI:0]);
  // Both operands are widened first so the product keeps all 27 significant bits
  assign raw_ext = 28'(raw_current);
  assign gain_ext = 28'($signed({1'b0, current_gain_factor}));
  assign product = raw_ext * gain_ext;
  // Arithmetic shift floors toward minus infinity; kept for cheap hardware
  assign scaled = (product >>> `GMC_GAIN_SHIFT) + 28'(current_offset_trim);

  always_ff @(posedge clk) begin
    if (rst) begin
      reported_current <= 16'h0000;
      current_valid <= 1'b0;
    end else begin
      current_valid <= raw_valid;
      if (raw_valid) begin
        // Saturate rather than wrap when a large gain overflows 16 bits
        if (scaled > 28'sh0007FFF) begin
          reported_current <= 16'h7FFF;
        end else if (scaled < -28'sh0008000) begin
          reported_current <= 16'h8000;
        end else begin
          reported_current <= scaled[15:0];
        end
      end
    end
  end

  // ****************************************
  // Temperature and front end select
  // ****************************************
  assign temperature_source_select = gmc_tsrc_e'(setup_r[`GMC_TSRC_BIT]);

  always_ff @(posedge clk) begin
    if (rst) begin
      temperature <= 16'h0000;
      pullup_strength_select <= 1'b0;
      sense_resistor_select <= 1'b0;
      thermistor_curve_word <= `GMC_CURVE_RST;
    end else begin
      pullup_strength_select <= setup_r[`GMC_PULLUP_BIT];
      sense_resistor_select <= setup_r[`GMC_SENSE_BIT];
      thermistor_curve_word <= curve_r;
      case (temperature_source_select)
        GMC_TSRC_DIE: temperature <= die_temperature;
        GMC_TSRC_THERM: temperature <= ext_override_en ? ext_temp_overwrite
                                                       : thermistor_temp;
        default: temperature <= die_temperature;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_setup_undef_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `GMC_OFF_SETUP |=> (reg_rdata & ~`GMC_SETUP_MASK) == 16'h0000)
    else $error("undefined setup bits read nonzero");
  a_pullup_follow: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `GMC_OFF_SETUP |=> ##1
      pullup_strength_select == $past(reg_wdata[`GMC_PULLUP_BIT], 2))
    else $error("pullup select did not follow write");
  a_sense_follow: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `GMC_OFF_SETUP |=> ##1
      sense_resistor_select == $past(reg_wdata[`GMC_SENSE_BIT], 2))
    else $error("sense select did not follow write");
  // Sampled reset in the antecedent: the edge that releases reset still loads zero
  a_temp_die: assert property (@(posedge clk) disable iff (rst)
    !rst && !setup_r[`GMC_TSRC_BIT] |=> temperature == $past(die_temperature))
    else $error("die temperature not routed");
  a_temp_therm: assert property (@(posedge clk) disable iff (rst)
    !rst && setup_r[`GMC_TSRC_BIT] && !ext_override_en
      |=> temperature == $past(thermistor_temp))
    else $error("thermistor temperature not routed");
  a_temp_override: assert property (@(posedge clk) disable iff (rst)
    !rst && setup_r[`GMC_TSRC_BIT] && ext_override_en
      |=> temperature == $past(ext_temp_overwrite))
    else $error("override temperature not routed");
  a_curve_track: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `GMC_OFF_CURVE |=> ##1 thermistor_curve_word == $past(reg_wdata, 2))
    else $error("curve word not applied");
  a_unity_gain: assert property (@(posedge clk) disable iff (rst)
    raw_valid && cal_r == 16'h4000 |=> reported_current == $past(raw_current))
    else $error("unity gain altered current");
  a_offset_add: assert property (@(posedge clk) disable iff (rst)
    raw_valid && cal_r == 16'h4001 && raw_current < 16'sh7FFF
      |=> reported_current == $past(raw_current) + 16'sh0001)
    else $error("offset trim not added");
  a_valid_delay: assert property (@(posedge clk) disable iff (rst)
    raw_valid |=> current_valid)
    else $error("current valid missing");
  a_setup_store: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `GMC_OFF_SETUP |=> (setup_r & 16'h1068) == 16'h0000)
    else $error("undefined setup bits stored");
  a_cal_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `GMC_OFF_CAL |=> reg_rdata == $past(cal_r))
    else $error("calibration word not read back");
  a_curve_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `GMC_OFF_CURVE |=> reg_rdata == $past(curve_r))
    else $error("curve word not read back");
  a_gain_double: assert property (@(posedge clk) disable iff (rst)
    raw_valid && cal_r == 16'h8000 && raw_current < 16'sh4000 && raw_current >= -16'sh4000
      |=> reported_current == $past(raw_current) + $past(raw_current))
    else $error("double gain not applied");
  a_offset_neg: assert property (@(posedge clk) disable iff (rst)
    raw_valid && cal_r == 16'h403F && raw_current != 16'sh8000
      |=> reported_current == $past(raw_current) - 16'sh0001)
    else $error("negative offset trim not added");
  a_sat_high: assert property (@(posedge clk) disable iff (rst)
    raw_valid && cal_r == 16'hFFC0 && raw_current == 16'sh7FFF
      |=> reported_current == 16'sh7FFF)
    else $error("positive overflow not saturated");
  a_sat_low: assert property (@(posedge clk) disable iff (rst)
    raw_valid && cal_r == 16'hFFC0 && raw_current == 16'sh8000
      |=> reported_current == 16'sh8000)
    else $error("negative overflow not saturated");
  a_valid_drop: assert property (@(posedge clk) disable iff (rst)
    !raw_valid |=> !current_valid)
    else $error("current valid too long");
  a_hold_current: assert property (@(posedge clk) disable iff (rst)
    !rst && !raw_valid |=> $stable(reported_current))
    else $error("reported current changed without sample");
  // Reset values are looked at on the first edge after release, so no disable here
  a_curve_reset: assert property (@(posedge clk)
    $fell(rst) |-> thermistor_curve_word == 16'h71BE)
    else $error("curve word reset value wrong");
  a_select_reset: assert property (@(posedge clk)
    $fell(rst) |-> !pullup_strength_select && !sense_resistor_select)
    else $error("front end selects not reset");
  a_tsrc_reset: assert property (@(posedge clk)
    $fell(rst) |-> setup_r[`GMC_TSRC_BIT])
    else $error("temperature source not reset to thermistor");

  // ****************************************
  // Cover points
  // ****************************************
  c_setup_write: cover property (@(posedge clk) reg_wr && reg_addr == `GMC_OFF_SETUP);
  c_therm_override: cover property (@(posedge clk) setup_r[`GMC_TSRC_BIT] && ext_override_en);
  c_sample: cover property (@(posedge clk) raw_valid && cal_r != `GMC_CAL_RST);
  c_saturate: cover property (@(posedge clk) current_valid && reported_current == 16'sh7FFF);
  c_setup_read: cover property (@(posedge clk) reg_rd && reg_addr == `GMC_OFF_SETUP);
endmodule : gmc_config

// [verification/gmc_sensor_model.sv]
`timescale 1ns/1ps
// ****
// Thermistor divider and die sensor
// ****
module gmc_sensor_model (
  input wire logic pullup_strength_select,
  output gmc_pkg::gmc_word_t die_temperature,
  output gmc_pkg::gmc_word_t thermistor_temp
);
  import gmc_pkg::*;
  assign die_temperature = 16'h0190;
  // Divider reading moves with pullup strength, so a stuck select shows up
  assign thermistor_temp = pullup_strength_select ? 16'h0220 : 16'h0120;
endmodule : gmc_sensor_model

// [verification/tb_gmc_config.sv]
`timescale 1ns/1ps
`include "gmc_defs.svh"
module tb_gmc_config;
  import gmc_pkg::*;
  logic clk, rst, wr, rd, rv, oe, cv, pu, ss;
  logic [8:0] a;
  gmc_word_t wd, rdat, dt, tt, ex, tmp, cw;
  gmc_cur_t raw, rc;
  int err_total, comparisons;
  gmc_config gmc_config_i (.clk(clk), .rst(rst), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .raw_current(raw), .raw_valid(rv), .die_temperature(dt),
    .thermistor_temp(tt), .ext_temp_overwrite(ex), .ext_override_en(oe),
    .reported_current(rc), .current_valid(cv), .temperature(tmp),
    .pullup_strength_select(pu), .sense_resistor_select(ss), .thermistor_curve_word(cw));
  gmc_sensor_model gmc_sensor_model_i (.pullup_strength_select(pu), .die_temperature(dt),
    .thermistor_temp(tt));
  // ****
  // Bus and compare helpers
  // ****
  task chk(string n, gmc_word_t e, gmc_word_t s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wrr(logic [8:0] ad, gmc_word_t d);
    @(posedge clk);
    wr <= 1'b1;
    a <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task rdr(logic [8:0] ad, gmc_word_t e);
    @(posedge clk);
    rd <= 1'b1;
    a <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdat);
  endtask : rdr
  task cur(gmc_cur_t r, gmc_cur_t e);
    @(posedge clk);
    rv <= 1'b1;
    raw <= r;
    @(posedge clk);
    rv <= 1'b0;
    #1 chk("valid", 16'h0001, {15'h0, cv});
    chk("current", e, rc);
    @(posedge clk);
    #1 chk("valid", 16'h0000, {15'h0, cv});
    chk("current", e, rc);
  endtask : cur
  task settle(gmc_word_t e);
    repeat (3) @(posedge clk);
    #1 chk("temperature", e, tmp);
  endtask : settle
  // ****
  // Scenarios
  // ****
  task t_regs;
    rdr(`GMC_OFF_CAL, 16'h4000);
    rdr(`GMC_OFF_SETUP, 16'h0010);
    rdr(`GMC_OFF_CURVE, 16'h71BE);
    chk("pullup", 16'h0000, {15'h0, pu});
    chk("sense", 16'h0000, {15'h0, ss});
    wrr(`GMC_OFF_SETUP, 16'h10FC);
    rdr(`GMC_OFF_SETUP, 16'h0094);
    chk("pullup", 16'h0001, {15'h0, pu});
    chk("sense", 16'h0001, {15'h0, ss});
    wrr(9'h1CB, 16'hFFFF);
    rdr(9'h1CB, 16'h0000);
    wrr(`GMC_OFF_SETUP, 16'h0000);
    @(posedge clk);
    #1 chk("sense", 16'h0000, {15'h0, ss});
  endtask : t_regs
  task t_temp;
    settle(16'h0190);
    wrr(`GMC_OFF_SETUP, 16'h0090);
    settle(16'h0220);
    @(posedge clk);
    oe <= 1'b1;
    ex <= 16'h5A5A;
    settle(16'h5A5A);
    wrr(`GMC_OFF_SETUP, 16'h0000);
    settle(16'h0190);
  endtask : t_temp
  task t_cur;
    cur(16'sd100, 16'sd100);
    wrr(`GMC_OFF_CAL, 16'h8000);
    cur(16'sd100, 16'sd200);
    wrr(`GMC_OFF_CAL, 16'h403F);
    cur(-16'sd100, -16'sd101);
    wrr(`GMC_OFF_CAL, 16'h4001);
    cur(16'sd100, 16'sd101);
    wrr(`GMC_OFF_CAL, 16'hFFC0);
    cur(16'sh7FFF, 16'sh7FFF);
    cur(16'sh8000, 16'sh8000);
    wrr(`GMC_OFF_CAL, 16'h4000);
  endtask : t_cur
  task t_curve;
    // A Beta of 3435 on a 10 kilohm part gives 0x71B0
    wrr(`GMC_OFF_CURVE, 16'h7000 + 16'(3245919 / 3435 - 512));
    rdr(`GMC_OFF_CURVE, 16'h71B0);
    chk("curve", 16'h71B0, cw);
  endtask : t_curve
  task t_reset;
    wrr(`GMC_OFF_SETUP, 16'h0084);
    wrr(`GMC_OFF_CAL, 16'h8000);
    wrr(`GMC_OFF_CURVE, 16'h1234);
    cur(16'sd100, 16'sd200);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk("pullup", 16'h0000, {15'h0, pu});
    chk("sense", 16'h0000, {15'h0, ss});
    chk("curve", 16'h71BE, cw);
    chk("current", 16'h0000, rc);
    rdr(`GMC_OFF_CAL, 16'h4000);
    rdr(`GMC_OFF_SETUP, 16'h0010);
    rdr(`GMC_OFF_CURVE, 16'h71BE);
  endtask : t_reset
  task end_of_test;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    // Whole run needs about 100 cycles
    repeat (2000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    {rst, wr, rd, rv, oe} <= 5'h10;
    a <= 9'h000;
    {wd, ex, raw} <= 48'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_temp();
    t_cur();
    t_curve();
    t_reset();
    end_of_test();
  end
endmodule : tb_gmc_config
